// File: inc/otc_pkg.sv
package otc_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ = 50_000_000;
	// Start switch settling interval, in milliseconds
	localparam int unsigned DEB_TIME_MS = 10;
	// Least time, held to at least one cycle; the cycle count is not rounded up
	localparam int unsigned DEB_CYCLES =
		(CLK_HZ / 1000 * DEB_TIME_MS + 0) > 0 ?
		(CLK_HZ / 1000 * DEB_TIME_MS) : 1;
	localparam int unsigned DEB_W = 20;
	// Clock output is the main clock divided by sixteen
	localparam int unsigned CLKOUT_DIV = 16;
	localparam int unsigned CLKOUT_W = $clog2(CLKOUT_DIV);

	// ************************************************************
	// Trim value
	// ************************************************************
	localparam int unsigned TRIM_W = 6;
	localparam logic [5:0] TRIM_MIN = 6'h00;
	localparam logic [5:0] TRIM_MAX = 6'h3F;
	localparam logic [5:0] TRIM_RST = 6'h20;

	// ************************************************************
	// Capture and measurement windows
	// ************************************************************
	localparam int unsigned CAP_W = 16;
	localparam int unsigned ACC_W = 18;
	localparam logic [1:0] SUB_CAPTURES = 2'h3; // Index of the last
	localparam logic [17:0] SUB_SLOW_MAX = 18'h0F3E;
	localparam logic [17:0] SUB_FAST_MIN = 18'h0F46;
	localparam logic [17:0] EXT_SLOW_MAX = 18'hF3E5;
	localparam logic [17:0] EXT_FAST_MIN = 18'hF462;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic {OTC_MODE_SUB, OTC_MODE_EXT} otc_mode_t;
	typedef enum logic [1:0] {OTC_IDLE, OTC_MEAS, OTC_EVAL} otc_state_t;

	// One finished capture from the timer channels
	typedef struct packed {
		logic valid;
		logic [CAP_W-1:0] count;
	} otc_cap_t;

endpackage

// File: hw/otc_capture.sv
`timescale 1ns/1ns
// ************************************************************
// Capture timer channel pair, 16-bit capture mode
// ************************************************************
module otc_capture #(
	parameter int unsigned W = otc_pkg::CAP_W
) (
	input wire logic clk, // Trimmed oscillator clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic clr, // Drop any capture in progress
	input wire logic start, // Trigger that opens an interval
	input wire logic stop, // Trigger that closes an interval
	output otc_pkg::otc_cap_t cap // Captured count, valid pulse
);
	import otc_pkg::*;

	logic run_q;
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_inc;
	logic closing;

	// Saturate so an overlong interval reads as very fast, never wraps
	assign cnt_inc = (&cnt_q) ? cnt_q : cnt_q + 1'b1;
	assign closing = run_q && stop;

	// Count cycles between triggers; a clear wins over everything
	always_ff @(posedge clk) begin
		if (srst || clr) begin
			run_q <= 1'b0;
			cnt_q <= '0;
			cap <= '0;
		end else begin
			cap.valid <= closing;
			if (closing) begin
				cap.count <= cnt_inc;
			end
			if (start) begin
				run_q <= 1'b1;
				cnt_q <= '0;
			end else begin
				if (closing) begin
					run_q <= 1'b0;
				end
				cnt_q <= run_q ? cnt_inc : '0;
			end
		end
	end

	// Capture only follows a closing trigger
	a_cap_cause: assert property (@(posedge clk) disable iff (srst)
		cap.valid |-> $past(closing) && !$past(clr))
		else $error("capture without closing trigger");

endmodule

// File: hw/otc_calibrator.sv
`timescale 1ns/1ns
module otc_calibrator #(
	parameter int unsigned DEB_CYCLES = otc_pkg::DEB_CYCLES
) (
	input wire logic clk, // Main clock, the trimmed oscillator
	input wire logic srst, // Synchronous reset, active high
	input wire logic sub_osc_in, // 32.768 kHz sub-clock pin
	input wire logic ext_ref_input_pin, // 512 Hz reference pin
	input wire logic start_switch_pin, // Start switch, pressed low
	input wire logic method_select_pin, // High picks external mode
	output logic [otc_pkg::TRIM_W-1:0] osc_trim_value, // Trim value
	output logic done_indicator_pin, // Finished inside window
	output logic busy, // Calibration run active
	output logic clock_out_pin // Main clock divided by 16
);
	import otc_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	localparam int unsigned NPIN = 4;
	localparam int unsigned P_SUB = 0;
	localparam int unsigned P_EXT = 1;
	localparam int unsigned P_START = 2;
	localparam int unsigned P_METH = 3;

	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] sync1_q;
	logic [NPIN-1:0] sync2_q;
	logic [NPIN-1:0] sync3_q;

	assign pins = {method_select_pin, start_switch_pin,
		ext_ref_input_pin, sub_osc_in};

	// Two flops per pin; third stage only feeds edge detection
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// ************************************************************
	// Start switch debounce
	// ************************************************************
	localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYCLES - 1);

	logic [DEB_W-1:0] deb_cnt_q;
	logic [DEB_W-1:0] deb_cnt_d;
	logic deb_lvl_q;
	logic deb_lvl_d;
	logic deb_diff;
	logic start_req;

	// Level must hold a full interval before it is believed
	assign deb_diff = sync2_q[P_START] != deb_lvl_q;
	assign deb_cnt_d = !deb_diff ? '0 : deb_cnt_q + 1'b1;
	assign deb_lvl_d = (deb_diff && deb_cnt_q == DEB_LAST) ?
		sync2_q[P_START] : deb_lvl_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			deb_cnt_q <= '0;
			deb_lvl_q <= 1'b1;
		end else begin
			deb_cnt_q <= (deb_lvl_d != deb_lvl_q) ? '0 : deb_cnt_d;
			deb_lvl_q <= deb_lvl_d;
		end
	end

	assign start_req = deb_lvl_q && !deb_lvl_d;

	// ************************************************************
	// Event link and capture channels
	// ************************************************************
	otc_mode_t mode_q;
	otc_state_t state_q;
	logic sub_rise;
	logic ext_rise;
	logic ext_fall;
	logic link_start;
	logic link_stop;
	logic cap_clr;
	logic step;
	otc_cap_t cap;

	assign sub_rise = sync2_q[P_SUB] && !sync3_q[P_SUB];
	assign ext_rise = sync2_q[P_EXT] && !sync3_q[P_EXT];
	assign ext_fall = !sync2_q[P_EXT] && sync3_q[P_EXT];

	// low level opens at fall, closes at rise
	assign link_start = (state_q != OTC_MEAS) ? 1'b0 :
		(mode_q == OTC_MODE_EXT) ? ext_fall : sub_rise;
	assign link_stop = (state_q != OTC_MEAS) ? 1'b0 :
		(mode_q == OTC_MODE_EXT) ? ext_rise : sub_rise;

	// drop stale capture on a step
	assign cap_clr = step || (state_q == OTC_IDLE);

	otc_capture #(
		.W(CAP_W)
	) u_cap (
		.clk(clk),
		.srst(srst),
		.clr(cap_clr),
		.start(link_start),
		.stop(link_stop),
		.cap(cap)
	);

	// ************************************************************
	// Accumulate and decide
	// ************************************************************
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_sum;
	logic [1:0] n_q;
	logic meas_last;
	logic [ACC_W-1:0] slow_max;
	logic [ACC_W-1:0] fast_min;
	logic is_slow;
	logic is_fast;
	logic in_win;
	logic at_max;
	logic at_min;
	logic blocked;
	logic evaluating;

	assign acc_sum = acc_q + ACC_W'(cap.count);

	assign meas_last = cap.valid &&
		(mode_q == OTC_MODE_EXT || n_q == SUB_CAPTURES);

	assign slow_max = (mode_q == OTC_MODE_EXT) ? EXT_SLOW_MAX : SUB_SLOW_MAX;
	assign fast_min = (mode_q == OTC_MODE_EXT) ? EXT_FAST_MIN : SUB_FAST_MIN;

	// same test on the single count
	assign is_slow = acc_q <= slow_max;
	assign is_fast = acc_q >= fast_min;
	assign in_win = !is_slow && !is_fast;

	assign at_max = osc_trim_value == TRIM_MAX;
	assign at_min = osc_trim_value == TRIM_MIN;
	assign blocked = (is_slow && at_max) || (is_fast && at_min);

	assign evaluating = state_q == OTC_EVAL;
	assign step = evaluating && !in_win && !blocked;

	// ************************************************************
	// Run sequencer
	// ************************************************************
	logic [TRIM_W-1:0] trim_q;
	logic done_q;

	// Mode is sampled once per run so limits never mix mid-run
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= OTC_IDLE;
			mode_q <= OTC_MODE_SUB;
			acc_q <= '0;
			n_q <= '0;
		end else begin
			unique case (state_q)
				OTC_IDLE: begin
					acc_q <= '0;
					n_q <= '0;
					if (start_req) begin
						mode_q <= sync2_q[P_METH] ? OTC_MODE_EXT :
							OTC_MODE_SUB;
						state_q <= OTC_MEAS;
					end
				end
				OTC_MEAS: begin
					if (cap.valid) begin
						acc_q <= acc_sum;
						n_q <= n_q + 1'b1;
					end
					if (meas_last) begin
						state_q <= OTC_EVAL;
					end
				end
				OTC_EVAL: begin
					acc_q <= '0;
					n_q <= '0;
					state_q <= step ? OTC_MEAS : OTC_IDLE;
				end
			endcase
		end
	end

	// Trim and done; a new start clears the done light
	always_ff @(posedge clk) begin
		if (srst) begin
			trim_q <= TRIM_RST;
			done_q <= 1'b0;
		end else begin
			if (step) begin
				trim_q <= is_slow ? trim_q + 1'b1 : trim_q - 1'b1;
			end
			if (state_q == OTC_IDLE && start_req) begin
				done_q <= 1'b0;
			end else if (evaluating && in_win) begin
				done_q <= 1'b1;
			end
		end
	end

	assign osc_trim_value = trim_q;
	assign done_indicator_pin = done_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			busy <= 1'b0;
		end else begin
			busy <= (state_q == OTC_IDLE) ? start_req : !(evaluating && !step);
		end
	end

	// ************************************************************
	// Clock output divider
	// ************************************************************
	logic [CLKOUT_W-1:0] div_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			div_q <= '0;
			clock_out_pin <= 1'b0;
		end else begin
			div_q <= div_q + 1'b1;
			clock_out_pin <= div_q[CLKOUT_W-1];
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_trim_range: assert property (trim_q <= TRIM_MAX)
		else $error("trim out of range");

	a_trim_step: assert property ($changed(trim_q) |->
		(trim_q == $past(trim_q) + 1'b1) ||
		(trim_q == $past(trim_q) - 1'b1))
		else $error("trim moved by more than one");

	a_sub_window: assert property (evaluating && mode_q == OTC_MODE_SUB &&
		acc_q > SUB_SLOW_MAX && acc_q < SUB_FAST_MIN |=>
		done_q && $stable(trim_q) && state_q == OTC_IDLE)
		else $error("sub window not completing");

	a_sub_slow: assert property (evaluating && mode_q == OTC_MODE_SUB &&
		acc_q <= SUB_SLOW_MAX && !at_max |=>
		trim_q == $past(trim_q) + 1'b1)
		else $error("slow sub count did not speed up");

	a_ext_window: assert property (evaluating && mode_q == OTC_MODE_EXT &&
		acc_q > EXT_SLOW_MAX && acc_q < EXT_FAST_MIN |=>
		done_q && $stable(trim_q))
		else $error("ext window not completing");

	a_ext_fast: assert property (evaluating && mode_q == OTC_MODE_EXT &&
		acc_q >= EXT_FAST_MIN && !at_min |=>
		trim_q == $past(trim_q) - 1'b1)
		else $error("fast ext count did not slow down");

	a_bound_stop: assert property (evaluating && blocked |=>
		!done_q && state_q == OTC_IDLE && $stable(trim_q))
		else $error("bound hit without stopping");

	a_idle_hold: assert property (state_q == OTC_IDLE && !start_req |=>
		state_q == OTC_IDLE)
		else $error("run began without start");

	a_sub_four: assert property (state_q == OTC_MEAS &&
		mode_q == OTC_MODE_SUB && cap.valid && n_q != SUB_CAPTURES |=>
		state_q == OTC_MEAS)
		else $error("sub sum closed before four captures");

	a_clkout_half: assert property ($changed(clock_out_pin) |=>
		$stable(clock_out_pin) [*7] ##1 $changed(clock_out_pin))
		else $error("clock output not divided by sixteen");

	a_step_clear: assert property (step |-> cap_clr ##1
		(state_q == OTC_MEAS && acc_q == '0 && !cap.valid))
		else $error("measurement not restarted after step");

endmodule

// File: verification/otc_ref_model.sv
`timescale 1ns/1ns
// ********************
// Reference sources
// ********************
module otc_ref_model (
	input wire logic clk, // Main clock
	input wire logic [5:0] trim, // Current trim value
	input wire logic ext_mode, // High sends the external wave
	input wire logic signed [31:0] base, // Span at trim zero, cycles
	input wire logic signed [31:0] gain, // Extra cycles per trim step
	output logic sub_clk, // Sub-clock stand-in
	output logic ext_ref // External reference stand-in
);
	int len;

	// Span follows trim, since a faster oscillator counts more
	initial begin
		sub_clk = 1'b0;
		ext_ref = 1'b1;
		forever begin
			len = base + gain * int'(trim);
			if (ext_mode) begin
				// low width carries the measured span
				// High phase kept short to save run time
				repeat (20) @(posedge clk);
				len = base + gain * int'(trim);
				#1 ext_ref = 1'b0;
				repeat (len) @(posedge clk);
				#1 ext_ref = 1'b1;
			end else begin
				@(posedge clk);
				#1 sub_clk = 1'b1;
				repeat (len - len / 2 - 1) @(posedge clk);
				#1 sub_clk = 1'b0;
				repeat (len / 2) @(posedge clk);
			end
		end
	end
endmodule

// File: verification/otc_calibrator_test.sv
`timescale 1ns/1ns
// ********************
// Calibrator bench
// ********************
module otc_calibrator_test;
	import otc_pkg::*;
	localparam int unsigned DEB = 16;
	localparam int LIMIT = 99000;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic start_sw_n = 1'b1;
	logic method = 1'b0;
	logic signed [31:0] m_base = '0;
	logic signed [31:0] m_gain = '0;
	logic sub_clk;
	logic ext_ref;
	logic [TRIM_W-1:0] trim;
	logic done;
	logic busy;
	logic clk_out;
	logic [TRIM_W-1:0] trim_prev = TRIM_RST;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;

	// Short debounce keeps the run brief
	otc_calibrator #(.DEB_CYCLES(DEB)) u_otc_calibrator (
		.clk(clk),
		.srst(srst),
		.sub_osc_in(sub_clk),
		.ext_ref_input_pin(ext_ref),
		.start_switch_pin(start_sw_n),
		.method_select_pin(method),
		.osc_trim_value(trim),
		.done_indicator_pin(done),
		.busy(busy),
		.clock_out_pin(clk_out)
	);

	// Reference sources track the trim value
	otc_ref_model u_otc_ref_model (
		.clk(clk),
		.trim(trim),
		.ext_mode(method),
		.base(m_base),
		.gain(m_gain),
		.sub_clk(sub_clk),
		.ext_ref(ext_ref)
	);

	// Main clock, 20 ns period
	initial begin
		forever #10 clk = ~clk;
	end

	task automatic check(input string what, input logic [17:0] seen,
		input logic [17:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard, counted as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// trim moves one step at a time
	always @(posedge clk) begin
		#2;
		if (srst === 1'b0 && trim !== trim_prev)
			check("trim step", 18'(trim > trim_prev ? trim - trim_prev :
				trim_prev - trim), 18'h0_0001);
		trim_prev = trim;
	end

	// ********************
	// Shared steps
	// ********************
	task automatic do_reset();
		@(posedge clk);
		#1 srst = 1'b1;
		repeat (5) @(posedge clk);
		#1 srst = 1'b0;
	endtask

	// press held past the debounce, then released
	task automatic press();
		@(posedge clk);
		#1 start_sw_n = 1'b0;
		repeat (DEB + 8) @(posedge clk);
		#1 start_sw_n = 1'b1;
		repeat (DEB + 8) @(posedge clk);
	endtask

	task automatic span(output int n);
		logic lvl;
		lvl = clk_out;
		n = 0;
		while (clk_out === lvl && n < 40) begin
			@(posedge clk);
			#2;
			n++;
		end
	endtask

	// Poke presses again mid-run, which must be ignored
	task automatic run(input logic ext, input int b, input int g,
		input logic [5:0] et, input logic ed, input logic poke);
		int n;
		do_reset();
		method = ext;
		m_base = b;
		m_gain = g;
		press();
		#2;
		check("busy", 18'(busy), 18'h0_0001);
		if (poke)
			press();
		n = 0;
		while (busy === 1'b1 && n < 100000) begin
			@(posedge clk);
			n++;
		end
		#2;
		check("busy end", 18'(busy), 18'h0_0000);
		check("trim", 18'(trim), 18'(et));
		check("done", 18'(done), 18'(ed));
	endtask

	// ********************
	// Scenarios
	// ********************
	task automatic t_reset();
		do_reset();
		check("trim", 18'(trim), 18'(TRIM_RST));
		check("done", 18'(done), 18'h0_0000);
		repeat (40) @(posedge clk);
		#2;
		check("idle busy", 18'(busy), 18'h0_0000);
	endtask

	task automatic t_clkout();
		int n;
		@(posedge clk);
		#2;
		span(n);
		span(n);
		check("clock out span", 18'(n), 18'h0_0008);
		span(n);
		check("clock out span", 18'(n), 18'h0_0008);
	endtask

	task automatic t_chatter();
		do_reset();
		@(posedge clk);
		repeat (4) begin
			#1 start_sw_n = 1'b0;
			repeat (5) @(posedge clk);
			#1 start_sw_n = 1'b1;
			repeat (5) @(posedge clk);
		end
		repeat (DEB + 10) @(posedge clk);
		#2;
		check("chatter busy", 18'(busy), 18'h0_0000);
	endtask

	// Sums 3896, 3900, then 3904 inside the window
	task automatic t_sub_slow();
		run(1'b0, 942, 1, 6'h22, 1'b1, 1'b1);
	endtask

	// Sum 3912 steps down, then 3908 ends inside
	task automatic t_sub_fast();
		run(1'b0, 946, 1, 6'h1F, 1'b1, 1'b0);
	endtask

	// Always slow, so trim climbs to its top and stops
	task automatic t_bound();
		run(1'b0, 10, 0, 6'h3F, 1'b0, 1'b0);
	endtask

	// Low width 1000 is slow, then 62500 is inside
	task automatic t_ext();
		run(1'b1, -1967000, 61500, 6'h21, 1'b1, 1'b0);
	endtask

	initial begin
		t_reset();
		t_clkout();
		t_chatter();
		t_sub_slow();
		t_sub_fast();
		t_bound();
		t_ext();
		tally_and_finish();
	end
endmodule
